// [sbtc_pkg.sv]
package sbtc_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAG = 8'h0C;
  localparam logic [7:0] IDX_LOW = 8'h0E;
  localparam logic [7:0] IDX_HIGH = 8'h0F;
  localparam logic [7:0] IDX_CTL = 8'h10;
  localparam logic [7:0] IDX_IE = 8'h8C;

  // timer_control fields
  localparam int CTL_W = 6;
  localparam int CTL_RUN_BIT = 0;
  localparam int CTL_CS_BIT = 1;
  localparam int CTL_SYNC_BIT = 2;
  localparam int CTL_OSC_BIT = 3;
  localparam int CTL_PS_LSB = 4;
  localparam int FLAG_OVF_BIT = 0;
  localparam int IE_OVF_BIT = 0;

  // reset values
  localparam logic [CTL_W-1:0] CTL_RESET = 6'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [1:0] DIR_RESET = 2'h3;
  localparam logic [1:0] DIR_INPUT = 2'h3;

  // instruction cycle is four reference clocks
  localparam int INSTR_DIV_DEFAULT = 4;

  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_FLAG = 3'b001,
    REG_LOW = 3'b010,
    REG_HIGH = 3'b011,
    REG_CTL = 3'b100,
    REG_IE = 3'b101
  } sbtc_reg_e;

  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_SYNC = 2'b01,
    MODE_ASYNC = 2'b10
  } sbtc_mode_e;

  function automatic sbtc_reg_e sbtc_decode(input logic [ADDR_W-1:0] addr);
    sbtc_reg_e sel;
    sel = REG_NONE;
    if (addr == {2'h0, IDX_FLAG, 2'h0}) begin
      sel = REG_FLAG;
    end else if (addr == {2'h0, IDX_LOW, 2'h0}) begin
      sel = REG_LOW;
    end else if (addr == {2'h0, IDX_HIGH, 2'h0}) begin
      sel = REG_HIGH;
    end else if (addr == {2'h0, IDX_CTL, 2'h0}) begin
      sel = REG_CTL;
    end else if (addr == {2'h0, IDX_IE, 2'h0}) begin
      sel = REG_IE;
    end
    return sel;
  endfunction : sbtc_decode

  // last prescaler count before a count step
  function automatic logic [2:0] sbtc_ps_last(input logic [1:0] ps);
    logic [2:0] last;
    last = 3'h0;
    if (ps == 2'h3) begin
      last = 3'h7;
    end else if (ps == 2'h2) begin
      last = 3'h3;
    end else if (ps == 2'h1) begin
      last = 3'h1;
    end
    return last;
  endfunction : sbtc_ps_last

endpackage : sbtc_pkg

// [sbtc_edge_if.sv]
`timescale 1ns/10ps
interface sbtc_edge_if;
  logic osc_sel;
  logic rise;
  modport core (output osc_sel, input rise);
  modport det (input osc_sel, output rise);
endinterface : sbtc_edge_if

// [sbtc_edge_det.sv]
`timescale 1ns/10ps
module sbtc_edge_det (
  input wire logic clk,
  input wire logic rst,
  input wire logic clock_pin,
  input wire logic osc_level,
  sbtc_edge_if.det bus
);
  import sbtc_pkg::*;

  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic osc_s1;
    logic osc_s2;
    logic prev;
  } sbtc_sync_s;

  // prev resets high, but pin_s1 and pin_s2 reset low, so a pin already high at release still gives an edge
  localparam sbtc_sync_s SYNC_RESET = '{pin_s1: 1'b0, pin_s2: 1'b0, osc_s1: 1'b0,
                                        osc_s2: 1'b0, prev: 1'b1};

  sbtc_sync_s st;
  sbtc_sync_s next_st;
  logic src;

  always_comb begin
    next_st = st;
    next_st.pin_s1 = clock_pin;
    next_st.pin_s2 = st.pin_s1;
    next_st.osc_s1 = osc_level;
    next_st.osc_s2 = st.osc_s1;
    src = bus.osc_sel ? st.osc_s2 : st.pin_s2;
    next_st.prev = src;
  end

  assign bus.rise = src & ~st.prev;

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= SYNC_RESET;
    end else begin
      st <= next_st;
    end
  end

endmodule : sbtc_edge_det

// [sbtc_top.sv]
`timescale 1ns/10ps
// Operation
// - clock_source_select 1 counts the external clock, 0 counts instruction cycles.
// - in timer operation the count steps once per instruction cycle after the prescaler.
// - in counter operation only rising edges of the external input step the count.
// - timer, synchronized counter and unsynchronized counter; sync_bypass only matters externally.
// - with the oscillator enabled both oscillator pins are inputs whatever the port direction says.
// - a trigger from the capture_compare_unit clears the count.
// - input_prescale_select 11, 10, 01, 00 divide by 8, 4, 2, 1.
// - osc_enable set starts the crystal oscillator and clear stops it.
// - the oscillator keeps running while the processor sleeps.
// - count_pair counts up from 0000h to FFFFh and wraps to 0000h.
// - each wrap sets overflow_flag, which stays set until software clears it.
// - the overflow request is raised only while overflow_irq_enable is set.
// - the count steps only while count_run is 1; while it is 0 only bus writes and compare triggers change it.
// - both count bytes are readable and writable.
// - a count write in the same cycle as a compare trigger wins over the trigger.
module sbtc_top #(
  parameter int INSTR_DIV = sbtc_pkg::INSTR_DIV_DEFAULT
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [sbtc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [sbtc_pkg::DATA_W-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [sbtc_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic OSC_OUTPUT_CLOCK_PIN,
  input wire logic OSC_LEVEL,
  input wire logic SLEEP,
  input wire logic CCP_RESET,
  input wire logic [1:0] PORT_DIR,
  output logic [1:0] PIN_DIR,
  output logic OSC_ENABLE,
  output logic OVF_IRQ,
  output logic [15:0] COUNT_PAIR
);
  import sbtc_pkg::*;

  localparam int IDIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;
  localparam logic [IDIV_W-1:0] IDIV_LAST = IDIV_W'(INSTR_DIV - 1);

  typedef struct packed {
    logic [CTL_W-1:0] ctl;
    logic [15:0] count;
    logic [2:0] pscnt;
    logic [IDIV_W-1:0] idiv;
    logic pend;
    logic ovf;
    logic ovf_ie;
    logic irq;
    logic [1:0] dir;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } sbtc_core_s;

  localparam sbtc_core_s ST_RESET = '{
    ctl: CTL_RESET,
    count: COUNT_RESET,
    pscnt: 3'h0,
    idiv: '0,
    pend: 1'b0,
    ovf: 1'b0,
    ovf_ie: 1'b0,
    irq: 1'b0,
    dir: DIR_RESET,
    prdata: '0,
    pready: 1'b0,
    pslverr: 1'b0
  };

  sbtc_core_s st;
  sbtc_core_s next_st;
  sbtc_reg_e sel;
  sbtc_edge_if edge_bus();

  assign sel = sbtc_decode(PADDR);
  // oscillator output replaces the pin as the external source
  assign edge_bus.osc_sel = st.ctl[CTL_OSC_BIT];

  sbtc_edge_det u_edge (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .clock_pin(OSC_OUTPUT_CLOCK_PIN),
    .osc_level(OSC_LEVEL),
    .bus(edge_bus)
  );

  always_comb begin
    logic setup;
    logic wr_acc;
    logic itick;
    logic evt;
    logic inc;
    logic ovf_set;
    sbtc_mode_e mode;
    setup = 1'b0;
    wr_acc = 1'b0;
    itick = 1'b0;
    evt = 1'b0;
    inc = 1'b0;
    ovf_set = 1'b0;
    mode = MODE_TIMER;
    next_st = st;

    // bus: answer one cycle after setup, zero wait states in access
    setup = PSEL & ~PENABLE;
    wr_acc = PSEL & PENABLE & st.pready & PWRITE & PSTRB[0];
    next_st.pready = setup;
    next_st.pslverr = setup & (sel == REG_NONE);
    if (setup) begin
      next_st.prdata = '0;
      case (sel)
        REG_FLAG: next_st.prdata[FLAG_OVF_BIT] = st.ovf;
        REG_IE: next_st.prdata[IE_OVF_BIT] = st.ovf_ie;
        REG_LOW: next_st.prdata[7:0] = st.count[7:0];
        REG_HIGH: next_st.prdata[7:0] = st.count[15:8];
        REG_CTL: next_st.prdata[CTL_W-1:0] = st.ctl;
        default: next_st.prdata = '0;
      endcase
    end

    // instruction cycle stops during sleep
    if (!SLEEP) begin
      itick = (st.idiv == IDIV_LAST);
      next_st.idiv = itick ? '0 : st.idiv + 1'b1;
    end

    if (!st.ctl[CTL_CS_BIT]) begin
      mode = MODE_TIMER;
    end else if (st.ctl[CTL_SYNC_BIT]) begin
      mode = MODE_ASYNC;
    end else begin
      mode = MODE_SYNC;
    end

    next_st.pend = 1'b0;
    case (mode)
      MODE_TIMER: begin
        evt = itick;
      end
      MODE_SYNC: begin
        // edge waits for the next instruction cycle; a new edge beats the clear
        evt = itick & st.pend;
        next_st.pend = edge_bus.rise | (st.pend & ~itick);
      end
      MODE_ASYNC: begin
        // no instruction cycle gating, so counting goes on in sleep
        evt = edge_bus.rise;
      end
      default: begin
        evt = 1'b0;
      end
    endcase

    if (st.ctl[CTL_RUN_BIT] && evt) begin
      if (st.pscnt >= sbtc_ps_last(st.ctl[CTL_PS_LSB +: 2])) begin
        next_st.pscnt = 3'h0;
        inc = 1'b1;
      end else begin
        next_st.pscnt = st.pscnt + 1'b1;
      end
    end

    if (wr_acc && (sel == REG_LOW || sel == REG_HIGH)) begin
      if (sel == REG_LOW) begin
        next_st.count[7:0] = PWDATA[7:0];
      end else begin
        next_st.count[15:8] = PWDATA[7:0];
      end
    end else if (CCP_RESET) begin
      // compare trigger clears without touching the overflow flag
      next_st.count = COUNT_RESET;
      next_st.pscnt = 3'h0;
    end else if (inc) begin
      next_st.count = st.count + 1'b1;
      ovf_set = (st.count == COUNT_MAX);
    end

    if (wr_acc && sel == REG_FLAG) begin
      next_st.ovf = PWDATA[FLAG_OVF_BIT];
    end
    if (ovf_set) begin
      next_st.ovf = 1'b1;
    end
    if (wr_acc && sel == REG_IE) begin
      next_st.ovf_ie = PWDATA[IE_OVF_BIT];
    end
    if (wr_acc && sel == REG_CTL) begin
      next_st.ctl = PWDATA[CTL_W-1:0];
    end

    next_st.irq = next_st.ovf & next_st.ovf_ie;
    // oscillator enable overrides the port direction of both pins
    next_st.dir = st.ctl[CTL_OSC_BIT] ? DIR_INPUT : PORT_DIR;
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign PIN_DIR = st.dir;
  // not gated by sleep; no start-up delay, software must wait
  assign OSC_ENABLE = st.ctl[CTL_OSC_BIT];
  assign OVF_IRQ = st.irq;
  assign COUNT_PAIR = st.count;

endmodule : sbtc_top

// [sbtc_properties.sv]
`timescale 1ns/10ps
module sbtc_properties #(
  parameter int INSTR_DIV = 4
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [sbtc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [sbtc_pkg::DATA_W-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic PREADY,
  input wire logic CCP_RESET,
  input wire logic [1:0] PIN_DIR,
  input wire logic OSC_ENABLE,
  input wire logic OVF_IRQ,
  input wire logic [15:0] COUNT_PAIR
);
  import sbtc_pkg::*;
  logic ie_sh;
  wire acc = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
  wire wlo = acc && PADDR == 12'h038;
  wire wcnt = wlo || acc && PADDR == 12'h03C;
  wire wfi = acc && (PADDR == 12'h030 || PADDR == 12'h230);
  // enable bit is not a port, so shadow it from the bus
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ie_sh <= 1'b0;
    end else if (acc && PADDR == 12'h230) begin
      ie_sh <= PWDATA[0];
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_setup; PSEL && !PENABLE; endsequence
  sequence s_wrap;
    $past(COUNT_PAIR) == 16'hFFFF && COUNT_PAIR == 16'h0000 && !$past(CCP_RESET || wcnt);
  endsequence
  property p_rdy; s_setup |=> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing");
  property p_dir; OSC_ENABLE && $past(OSC_ENABLE) |-> PIN_DIR == 2'h3; endproperty
  a_dir: assert property (p_dir) else $error("pins not inputs");
  property p_clr; $past(CCP_RESET) && !$past(wcnt) |-> COUNT_PAIR == 16'h0000; endproperty
  a_clr: assert property (p_clr) else $error("count not cleared");
  property p_wr; $past(CCP_RESET && wlo) |-> COUNT_PAIR[7:0] == $past(PWDATA[7:0]); endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_step;
    COUNT_PAIR != $past(COUNT_PAIR) && !$past(CCP_RESET || wcnt || SYS_RST)
      |-> COUNT_PAIR == $past(COUNT_PAIR) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_ovf; s_wrap ##0 ie_sh |-> ##[1:2] OVF_IRQ; endproperty
  a_ovf: assert property (p_ovf) else $error("no overflow request");
  property p_mask; !ie_sh && !$past(ie_sh) |-> !OVF_IRQ; endproperty
  a_mask: assert property (p_mask) else $error("masked request");
  property p_hold; $fell(OVF_IRQ) |-> $past(wfi); endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");
endmodule : sbtc_properties
bind sbtc_top sbtc_properties #(.INSTR_DIV(INSTR_DIV)) u_props (.REF_CLK, .SYS_RST, .PSEL,
  .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PREADY, .CCP_RESET, .PIN_DIR, .OSC_ENABLE,
  .OVF_IRQ, .COUNT_PAIR);

// [sbtc_src_model.sv]
`timescale 1ns/10ps
// far-side clock source, idle low between bursts
module sbtc_src_model (
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] pulses,
  input wire logic [3:0] half,
  output logic line,
  output logic busy
);
  initial begin
    line = 1'b0;
    busy = 1'b0;
  end
  // half of 3 or more keeps each level past the two-flop synchroniser
  always @(posedge clk) begin
    if (start && !busy) begin
      busy <= 1'b1;
      repeat (pulses) begin
        repeat (half) @(posedge clk);
        line <= 1'b1;
        repeat (half) @(posedge clk);
        line <= 1'b0;
      end
      busy <= 1'b0;
    end
  end
endmodule : sbtc_src_model

// [tb.sv]
`timescale 1ns/10ps
module tb;
  localparam int DIV = 2;
  localparam logic [11:0] AF = 12'h030, AL = 12'h038, AH = 12'h03C, CT = 12'h040, AE = 12'h230;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, sleep = 1'b0, capture_compare_unit = 1'b0;
  logic go_p = 1'b0, go_o = 1'b0, prdy, perr, err, pin, osc, bp, bo, osc_en, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] pdir = 2'h0, pin_dir;
  logic [7:0] np = 8'h08;
  logic [3:0] hp = 4'h3;
  logic [15:0] cnt, c0;
  logic [11:0] at [6] = '{AF, AL, AH, CT, AE, 12'h100};
  logic [7:0] cm [3] = '{8'h07, 8'h03, 8'h0F};
  int mismatches = 0, n_tests = 0, t, ps;
  sbtc_top #(.INSTR_DIV(DIV)) dut (.REF_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(prdy),
    .PSLVERR(perr), .OSC_OUTPUT_CLOCK_PIN(pin), .OSC_LEVEL(osc), .SLEEP(sleep), .CCP_RESET(capture_compare_unit),
    .PORT_DIR(pdir), .PIN_DIR(pin_dir), .OSC_ENABLE(osc_en), .OVF_IRQ(irq), .COUNT_PAIR(cnt));
  sbtc_src_model u_pin (.clk(clk), .start(go_p), .pulses(np), .half(hp), .line(pin), .busy(bp));
  sbtc_src_model u_osc (.clk(clk), .start(go_o), .pulses(np), .half(hp), .line(osc), .busy(bo));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic c);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    capture_compare_unit <= c;
    // look between edges so the answer is settled; it stands through the next rising edge
    do begin
      @(negedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
    end
    rd = prdata;
    err = perr;
    @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
    capture_compare_unit <= 1'b0;
  endtask : apb
  task automatic wait_chg(output int n);
    logic [15:0] c;
    c = cnt;
    n = 0;
    while (cnt === c && n < 99) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_chg
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hA1FC8161));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (at[i]) begin
      apb(0, at[i], 0, 0);
      chk(rd, 0);
      chk(err, at[i] == 12'h100);
    end
    apb(1, CT, 32'hC0, 0);
    apb(0, CT, 0, 0);
    chk(rd, 0);
    $display("map done");
    for (ps = 0; ps < 4; ps++) begin
      apb(1, CT, 32'h1 | ps << 4, 0);
      wait_chg(t);
      wait_chg(t);
      chk(t, DIV << ps);
    end
    apb(1, CT, 32'h30, 0);
    @(posedge clk);
    c0 = cnt;
    repeat (40) @(posedge clk);
    chk(cnt, c0);
    $display("timer done");
    for (int m = 0; m < 3; m++) begin
      ps = $urandom_range(3);
      pdir <= 2'($urandom);
      np <= 8'($urandom_range(40, 8));
      hp <= 4'($urandom_range(9, 3));
      apb(1, CT, cm[m] | ps << 4, 0);
      // oscillator has no start-up timer, so software waits
      repeat (20) @(posedge clk);
      chk(osc_en, m == 2);
      chk(pin_dir, m == 2 ? 2'h3 : pdir);
      capture_compare_unit <= 1'b1;
      @(posedge clk);
      capture_compare_unit <= 1'b0;
      @(posedge clk);
      chk(cnt, 0);
      sleep <= m != 1;
      go_o <= m == 2;
      go_p <= m != 2;
      @(posedge clk);
      go_o <= 1'b0;
      go_p <= 1'b0;
      @(posedge clk);
      t = 0;
      while ((bp || bo) && t < 999) begin
        @(posedge clk);
        t++;
      end
      repeat (8) @(posedge clk);
      sleep <= 1'b0;
      chk(cnt, np >> ps);
    end
    $display("external done");
    apb(1, CT, 0, 0);
    apb(1, AH, 32'hFF, 0);
    apb(1, AL, 32'hFD, 0);
    apb(0, AH, 0, 0);
    chk(rd, 32'hFF);
    apb(1, AE, 1, 0);
    apb(1, CT, 1, 0);
    t = 0;
    while (irq !== 1'b1 && t < 99) begin
      @(posedge clk);
      t++;
    end
    chk(irq, 1);
    chk(cnt < 16'h0010, 1);
    apb(1, AF, 0, 0);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    apb(1, AE, 0, 0);
    apb(1, AH, 32'hFF, 0);
    repeat (600) @(posedge clk);
    apb(0, AF, 0, 0);
    chk(rd, 1);
    chk(irq, 0);
    $display("overflow done");
    apb(1, CT, 0, 0);
    apb(1, AL, 32'h5A, 1);
    apb(0, AL, 0, 0);
    chk(rd, 32'h5A);
    $display("collision done");
    end_sim();
  end
endmodule : tb
